// [rtl/csm_defs.vh]
`ifndef CSM_DEFS_VH
`define CSM_DEFS_VH

// Register offsets (byte addresses)
`define CSM_OFF_CTRL1   8'h00
`define CSM_OFF_CTRL2   8'h04
`define CSM_OFF_CTRL3   8'h08
`define CSM_OFF_STAT    8'h0C
`define CSM_OFF_RSE     8'h10
`define CSM_OFF_TSE     8'h14
`define CSM_PAGE_RXB    4'h2
`define CSM_PAGE_TXB    4'h3

// Decoded register selects
`define CSM_SEL_CTRL1   4'h0
`define CSM_SEL_CTRL2   4'h1
`define CSM_SEL_CTRL3   4'h2
`define CSM_SEL_STAT    4'h3
`define CSM_SEL_RSE     4'h4
`define CSM_SEL_TSE     4'h5
`define CSM_SEL_RXB     4'h6
`define CSM_SEL_TXB     4'h7
`define CSM_SEL_NONE    4'hF

// Control 1 bits
`define CSM_EN          15
`define CSM_LOOP        11
`define CSM_SCKD        10
`define CSM_FSD         8
`define CSM_UNDERFLOW_MODE        7
`define CSM_SDOM        6

// Writable bit masks, reset value
`define CSM_MASK_CTRL1  16'hAFE3
`define CSM_MASK_CTRL2  16'h0DEF
`define CSM_MASK_CTRL3  16'h0FFF
`define CSM_RST_REG     16'h0000

// Control 2 and 3 fields
`define CSM_BUFFER_LENGTH        11:10
`define CSM_FLEN        8:5
`define CSM_WSZ         3:0
`define CSM_BCG         11:0

`endif

// [rtl/csm_codec_serial.v]
// Register access over APB and the register offsets were decided locally.
`include "csm_defs.vh"

module csm_codec_serial #(
    parameter AW = 8
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst,
    // APB slave
    input  wire [AW-1:0] paddr,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [31:0]   pwdata,
    output wire [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    // Bit clock pin
    input  wire          bit_clock_pin_i,
    output wire          bit_clock_pin_o,
    output wire          bit_clock_pin_oe_n,
    // Frame sync pin
    input  wire          frame_sync_pin_i,
    output wire          frame_sync_pin_o,
    output wire          frame_sync_pin_oe_n,
    // Serial data pins
    output wire          serial_out_pin_o,
    output wire          serial_out_pin_oe_n,
    input  wire          serial_in_pin_i
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [15:0] ctrl1_ff;
    reg  [15:0] ctrl2_ff;
    reg  [15:0] ctrl3_ff;
    reg  [15:0] rse_ff;
    reg  [15:0] tse_ff;
    reg         rfull_ff;
    reg         rov_ff;
    reg         transmit_underflow_ff;
    reg         tempty_ff;
    reg         txwr_ff;
    reg  [1:0]  ptr_ff;
    reg  [3:0]  slot_ff;
    reg  [3:0]  bit_ff;
    reg         act_ff;
    reg  [15:0] sh_ff;
    reg         sck_s1_ff;
    reg         sck_s2_ff;
    reg         sck_s3_ff;
    reg         fs_s1_ff;
    reg         fs_s2_ff;
    reg         sdi_s1_ff;
    reg         sdi_s2_ff;
    reg         fs_last_ff;
    reg  [11:0] div_ff;
    reg         sck_o_ff;
    reg  [8:0]  fcnt_ff;
    reg         fs_o_ff;
    reg         sdo_o_ff;
    reg         sdo_oe_n_ff;
    reg         sck_oe_n_ff;
    reg         fs_oe_n_ff;
    reg  [31:0] prdata_ff;
    reg         pready_ff;
    reg         pslverr_ff;
    reg  [31:0] nxt_rdata;
    wire [63:0] rxb_v;
    wire [63:0] txb_v;
    wire [63:0] shr_v;
    wire [63:0] sht_v;
    wire [63:0] src_v;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by read mux and write strobes

    function [3:0] csm_dec;
        input [AW-1:0] a;
        begin
            if (a == `CSM_OFF_CTRL1) begin
                csm_dec = `CSM_SEL_CTRL1;
            end else if (a == `CSM_OFF_CTRL2) begin
                csm_dec = `CSM_SEL_CTRL2;
            end else if (a == `CSM_OFF_CTRL3) begin
                csm_dec = `CSM_SEL_CTRL3;
            end else if (a == `CSM_OFF_STAT) begin
                csm_dec = `CSM_SEL_STAT;
            end else if (a == `CSM_OFF_RSE) begin
                csm_dec = `CSM_SEL_RSE;
            end else if (a == `CSM_OFF_TSE) begin
                csm_dec = `CSM_SEL_TSE;
            end else if (a[7:4] == `CSM_PAGE_RXB && a[1:0] == 2'h0) begin
                csm_dec = `CSM_SEL_RXB;
            end else if (a[7:4] == `CSM_PAGE_TXB && a[1:0] == 2'h0) begin
                csm_dec = `CSM_SEL_TXB;
            end else begin
                csm_dec = `CSM_SEL_NONE;
            end
        end
    endfunction

    // Left-justify a word of ws+1 bits held in the low bits
    function [15:0] csm_ljust;
        input [15:0] w;
        input [3:0]  ws;
        begin
            csm_ljust = w << (4'hF - ws);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Field views

    wire       en    = ctrl1_ff[`CSM_EN];
    wire       loop  = ctrl1_ff[`CSM_LOOP];
    wire       sckd  = ctrl1_ff[`CSM_SCKD];
    wire       fsd   = ctrl1_ff[`CSM_FSD];
    wire       underflow_mode  = ctrl1_ff[`CSM_UNDERFLOW_MODE];
    wire       sdom  = ctrl1_ff[`CSM_SDOM];
    wire [1:0] buffer_length  = ctrl2_ff[`CSM_BUFFER_LENGTH];
    wire [3:0] flen  = ctrl2_ff[`CSM_FLEN];
    wire [3:0] ws    = ctrl2_ff[`CSM_WSZ];
    wire [11:0] bit_clock_divider  = ctrl3_ff[`CSM_BCG];
    wire [3:0] sel   = csm_dec(paddr);
    wire [1:0] bidx  = paddr[3:2];
    wire       acc   = psel & penable & pready_ff;
    wire       wr    = acc & pwrite;
    wire       rd    = acc & ~pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Bit clock edges: synchronised pin or internal divider

    wire gen_tog = en & ~sckd & (div_ff == bit_clock_divider);
    wire sck_r   = ~sck_s3_ff & sck_s2_ff;
    wire sck_f   = sck_s3_ff & ~sck_s2_ff;
    wire rise    = en & (sckd ? sck_r : (gen_tog & ~sck_o_ff));
    wire fall    = en & (sckd ? sck_f : (gen_tog & sck_o_ff));

    // Frame sync source and start-of-frame event
    wire fs_src  = fsd ? fs_s2_ff : fs_o_ff;
    wire start   = rise & fs_src & ~fs_last_ff;
    wire sdi_bit = loop ? sdo_o_ff : sdi_s2_ff;

    // Frame length in bits, at most 16 slots of 16 bits
    wire [8:0] frm_bits = ({5'h0, flen} + 9'h001) * ({5'h0, ws} + 9'h001);

    ////////////////////////////////////////////////////////////////////////
    // Word and block bookkeeping

    wire        used   = rse_ff[slot_ff] | tse_ff[slot_ff];
    wire        wend   = rise & act_ff & (bit_ff == ws);
    wire        wrap   = wend & used & (ptr_ff == buffer_length);
    wire [1:0]  p_nxt  = wrap ? 2'h0 : (ptr_ff + {1'b0, wend & used});
    wire [15:0] rx_wd  = csm_ljust({sh_ff[14:0], sdi_bit}, ws);
    wire        rx_st  = wend & rse_ff[slot_ff];
    wire        rf_clr = rd & (sel == `CSM_SEL_RXB) & (bidx == buffer_length);
    wire        te_clr = wr & (sel == `CSM_SEL_TXB) & (bidx == buffer_length);
    wire [15:0] ld_wd  = wrap ? src_v[15:0] : sht_v[16*p_nxt +: 16];

    ////////////////////////////////////////////////////////////////////////
    // Per-word storage: software registers and serial-side shadows

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_buf
            reg [15:0] rxb_ff;
            reg [15:0] txb_ff;
            reg [15:0] shr_ff;
            reg [15:0] sht_ff;
            assign rxb_v[16*gi +: 16] = rxb_ff;
            assign txb_v[16*gi +: 16] = txb_ff;
            assign shr_v[16*gi +: 16] = shr_ff;
            assign sht_v[16*gi +: 16] = sht_ff;
            // Unwritten block sends the last value or zeros
            assign src_v[16*gi +: 16] = (txwr_ff | underflow_mode) ? txb_ff : 16'h0000;
            // rxb_ff and sht_ff move only at block wrap, so software never races the shifter
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    rxb_ff <= `CSM_RST_REG;
                    txb_ff <= `CSM_RST_REG;
                    shr_ff <= `CSM_RST_REG;
                    sht_ff <= `CSM_RST_REG;
                end else begin
                    if (wr && sel == `CSM_SEL_TXB && bidx == gi) begin
                        txb_ff <= pwdata[15:0];
                    end
                    if (rx_st && ptr_ff == gi) begin
                        shr_ff <= rx_wd;
                    end
                    if (wrap) begin
                        rxb_ff <= (rx_st && ptr_ff == gi) ? rx_wd : shr_ff;
                        sht_ff <= src_v[16*gi +: 16];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage read only by second

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_s3_ff <= 1'b0;
            fs_s1_ff  <= 1'b0;
            fs_s2_ff  <= 1'b0;
            sdi_s1_ff <= 1'b0;
            sdi_s2_ff <= 1'b0;
        end else begin
            sck_s1_ff <= bit_clock_pin_i;
            sck_s2_ff <= sck_s1_ff;
            sck_s3_ff <= sck_s2_ff; // Edge history
            fs_s1_ff  <= frame_sync_pin_i;
            fs_s2_ff  <= fs_s1_ff;
            sdi_s1_ff <= serial_in_pin_i;
            sdi_s2_ff <= sdi_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit clock generator, period 2*(divider+1) cycles

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff   <= 12'h000;
            sck_o_ff <= 1'b0;
        end else if (!en || sckd) begin
            div_ff   <= 12'h000;
            sck_o_ff <= 1'b0;
        end else if (gen_tog) begin
            div_ff   <= 12'h000;
            sck_o_ff <= ~sck_o_ff;
        end else begin
            div_ff   <= div_ff + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sync generator: one bit wide, in the bit before slot 0

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fcnt_ff <= 9'h000;
            fs_o_ff <= 1'b0;
        end else if (!en || fsd) begin
            fcnt_ff <= 9'h000;
            fs_o_ff <= 1'b0;
        end else if (fall) begin
            fs_o_ff <= (fcnt_ff == 9'h000);
            fcnt_ff <= (fcnt_ff == frm_bits - 9'h001) ? 9'h000 : fcnt_ff + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shifter, bit and slot counters, word pointer

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            act_ff     <= 1'b0;
            bit_ff     <= 4'h0;
            slot_ff    <= 4'h0;
            ptr_ff     <= 2'h0;
            sh_ff      <= 16'h0000;
            fs_last_ff <= 1'b0;
        end else if (!en) begin
            act_ff     <= 1'b0;
            bit_ff     <= 4'h0;
            slot_ff    <= 4'h0;
            ptr_ff     <= 2'h0;
            fs_last_ff <= 1'b0;
        end else if (rise) begin
            fs_last_ff <= fs_src;
            ptr_ff     <= p_nxt;
            if (wend) begin
                bit_ff  <= 4'h0;
                slot_ff <= slot_ff + 4'h1;
                sh_ff   <= ld_wd;
                if (slot_ff == flen) begin
                    act_ff <= 1'b0;
                end
            end else if (act_ff) begin
                bit_ff <= bit_ff + 4'h1;
                sh_ff  <= {sh_ff[14:0], sdi_bit};
            end
            // A new frame overrides whatever word was ending
            if (start) begin
                act_ff  <= 1'b1;
                bit_ff  <= 4'h0;
                slot_ff <= 4'h0;
                sh_ff   <= ld_wd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers; enables are low while driving

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_oe_n_ff <= 1'b1;
            fs_oe_n_ff  <= 1'b1;
            sdo_o_ff    <= 1'b0;
            sdo_oe_n_ff <= 1'b1;
        end else begin
            sck_oe_n_ff <= ~(en & ~sckd);
            fs_oe_n_ff  <= ~(en & ~fsd);
            if (!en) begin
                sdo_o_ff    <= 1'b0;
                sdo_oe_n_ff <= 1'b1;
            end else if (fall) begin
                if (act_ff && tse_ff[slot_ff]) begin
                    sdo_o_ff    <= sh_ff[15];
                    sdo_oe_n_ff <= 1'b0;
                end else begin
                    sdo_o_ff    <= 1'b0;
                    sdo_oe_n_ff <= sdom;
                end
            end else if (!act_ff) begin
                // Idle level at once after enable, not only from the next fall
                sdo_o_ff    <= 1'b0;
                sdo_oe_n_ff <= sdom;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; hardware set wins over software clear, except rov_ff, where the clear wins

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rfull_ff  <= 1'b0;
            rov_ff    <= 1'b0;
            transmit_underflow_ff   <= 1'b0;
            tempty_ff <= 1'b0;
            txwr_ff   <= 1'b0;
        end else begin
            if (wrap) begin
                rfull_ff <= 1'b1;
            end else if (rf_clr) begin
                rfull_ff <= 1'b0;
            end
            if (wrap && rfull_ff && !rf_clr) begin
                rov_ff <= 1'b1;
            end else if (rf_clr) begin
                rov_ff <= 1'b0;
            end
            if (wrap) begin
                tempty_ff <= 1'b1;
            end else if (te_clr) begin
                tempty_ff <= 1'b0;
            end
            if (wrap && !txwr_ff) begin
                transmit_underflow_ff <= 1'b1;
            end else if (te_clr) begin
                transmit_underflow_ff <= 1'b0;
            end
            if (te_clr) begin
                txwr_ff <= 1'b1;
            end else if (wrap) begin
                txwr_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl1_ff <= `CSM_RST_REG;
            ctrl2_ff <= `CSM_RST_REG;
            ctrl3_ff <= `CSM_RST_REG;
            rse_ff   <= `CSM_RST_REG;
            tse_ff   <= `CSM_RST_REG;
        end else if (wr) begin
            if (sel == `CSM_SEL_CTRL1) begin
                ctrl1_ff <= pwdata[15:0] & `CSM_MASK_CTRL1;
            end else if (sel == `CSM_SEL_CTRL2) begin
                ctrl2_ff <= pwdata[15:0] & `CSM_MASK_CTRL2;
            end else if (sel == `CSM_SEL_CTRL3) begin
                ctrl3_ff <= pwdata[15:0] & `CSM_MASK_CTRL3;
            end else if (sel == `CSM_SEL_RSE) begin
                rse_ff   <= pwdata[15:0];
            end else if (sel == `CSM_SEL_TSE) begin
                tse_ff   <= pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; status bits 15-12 and 7-4 read as zero

    always @* begin
        nxt_rdata = 32'h00000000;
        if (sel == `CSM_SEL_CTRL1) begin
            nxt_rdata[15:0] = ctrl1_ff;
        end else if (sel == `CSM_SEL_CTRL2) begin
            nxt_rdata[15:0] = ctrl2_ff;
        end else if (sel == `CSM_SEL_CTRL3) begin
            nxt_rdata[15:0] = ctrl3_ff;
        end else if (sel == `CSM_SEL_STAT) begin
            nxt_rdata[15:0] = {4'h0, slot_ff, 4'h0, rov_ff, rfull_ff, transmit_underflow_ff, tempty_ff};
        end else if (sel == `CSM_SEL_RSE) begin
            nxt_rdata[15:0] = rse_ff;
        end else if (sel == `CSM_SEL_TSE) begin
            nxt_rdata[15:0] = tse_ff;
        end else if (sel == `CSM_SEL_RXB) begin
            nxt_rdata[15:0] = rxb_v[16*bidx +: 16];
        end else if (sel == `CSM_SEL_TXB) begin
            nxt_rdata[15:0] = txb_v[16*bidx +: 16];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: data captured at setup, ready in first access cycle

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff <= psel & ~penable;
            if (psel && !penable) begin
                pslverr_ff <= (sel == `CSM_SEL_NONE);
                prdata_ff  <= pwrite ? 32'h00000000 : nxt_rdata;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Outputs straight from flops
    assign prdata              = prdata_ff;
    assign pready              = pready_ff;
    assign pslverr             = pslverr_ff;
    assign bit_clock_pin_o     = sck_o_ff;
    assign bit_clock_pin_oe_n  = sck_oe_n_ff;
    assign frame_sync_pin_o    = fs_o_ff;
    assign frame_sync_pin_oe_n = fs_oe_n_ff;
    assign serial_out_pin_o    = sdo_o_ff;
    assign serial_out_pin_oe_n = sdo_oe_n_ff;

endmodule

// [test/csm_codec_properties.sv]
`include "csm_defs.vh"

module csm_codec_properties #(
    parameter AW = 8
) (
    // Clock and reset
    input wire          clk,
    input wire          rst,
    // APB
    input wire [AW-1:0] paddr,
    input wire          psel,
    input wire          penable,
    input wire          pwrite,
    input wire [31:0]   pwdata,
    input wire [31:0]   prdata,
    input wire          pready,
    input wire          pslverr,
    // Pins
    input wire          bit_clock_pin_i,
    input wire          bit_clock_pin_o,
    input wire          bit_clock_pin_oe_n,
    input wire          frame_sync_pin_i,
    input wire          frame_sync_pin_o,
    input wire          frame_sync_pin_oe_n,
    input wire          serial_out_pin_o,
    input wire          serial_out_pin_oe_n,
    input wire          serial_in_pin_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] c1_ff;
    logic [1:0]  age_ff;
    wire         set = age_ff == 2'h3;
    wire         en  = c1_ff[`CSM_EN];

    // Control 1 shadow; pins are judged only once a write has settled
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            c1_ff  <= 16'h0000;
            age_ff <= 2'h3;
        end else if (psel && penable && pready && pwrite && paddr == `CSM_OFF_CTRL1) begin
            c1_ff  <= pwdata[15:0] & `CSM_MASK_CTRL1;
            age_ff <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end

    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_answer;
        s_setup |=> s_answer;
    endproperty
    property p_refuse;
        pslverr |-> pready && prdata == 32'h00000000;
    endproperty
    property p_off;
        set && !en |-> bit_clock_pin_oe_n && frame_sync_pin_oe_n && serial_out_pin_oe_n;
    endproperty
    property p_sck_dir;
        set && en |-> bit_clock_pin_oe_n == c1_ff[`CSM_SCKD];
    endproperty
    property p_fs_dir;
        set && en |-> frame_sync_pin_oe_n == c1_ff[`CSM_FSD];
    endproperty
    property p_sck_idle;
        set && bit_clock_pin_oe_n |-> !bit_clock_pin_o;
    endproperty
    property p_fs_idle;
        set && frame_sync_pin_oe_n |-> !frame_sync_pin_o;
    endproperty
    property p_sdo_low;
        set && en && !c1_ff[`CSM_SDOM] |-> !serial_out_pin_oe_n;
    endproperty

    a_answer: assert property (p_answer) else $error("pready did not pulse once after setup");
    a_refuse: assert property (p_refuse) else $error("error answer carried data");
    a_off: assert property (p_off) else $error("disabled block drives a pin");
    a_sck_dir: assert property (p_sck_dir) else $error("bit clock direction wrong");
    a_fs_dir: assert property (p_fs_dir) else $error("frame sync direction wrong");
    a_sck_idle: assert property (p_sck_idle) else $error("released bit clock not low");
    a_fs_idle: assert property (p_fs_idle) else $error("released frame sync not low");
    a_sdo_low: assert property (p_sdo_low) else $error("data out released in drive-low mode");
endmodule

bind csm_codec_serial csm_codec_properties #(.AW(AW)) u_props (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock_pin_i(bit_clock_pin_i), .bit_clock_pin_o(bit_clock_pin_o),
    .bit_clock_pin_oe_n(bit_clock_pin_oe_n), .frame_sync_pin_i(frame_sync_pin_i),
    .frame_sync_pin_o(frame_sync_pin_o), .frame_sync_pin_oe_n(frame_sync_pin_oe_n),
    .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_n(serial_out_pin_oe_n),
    .serial_in_pin_i(serial_in_pin_i));

// [test/csm_codec_partner.sv]
module csm_codec_partner (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Bench control
    input  wire        ext,
    input  wire [15:0] word,
    // Pins toward the device
    output logic       sck,
    output logic       fs,
    output logic       sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned div_cnt;
    int unsigned bit_no;

    // Half period of five cycles keeps above the synchroniser's minimum
    always @(posedge clk or posedge rst) begin
        if (rst || !ext) begin
            div_cnt <= 0;
            bit_no  <= 16;
            sck     <= 1'b0;
            fs      <= 1'b0;
            sdi     <= !rst & !sdi; // Idle data toggles so a stuck line shows
        end else if (div_cnt != 4) begin
            div_cnt <= div_cnt + 1;
        end else begin
            div_cnt <= 0;
            sck     <= !sck;
            // Falling edge: next bit, MSB first, sync bit between frames
            if (sck) begin
                bit_no <= (bit_no == 16) ? 0 : bit_no + 1;
                fs     <= (bit_no == 15);
                sdi    <= (bit_no == 16) ? word[15] : (bit_no < 15) ? word[14 - bit_no] : !sdi;
            end
        end
    end
endmodule

// [test/tb_csm_codec_serial.sv]
`include "csm_defs.vh"

module tb_csm_codec_serial;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        ext = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [31:0] q;
    logic        e;
    int          fail_count = 0;
    int          comparisons = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, sck_o, sck_oe_n, fs_o, fs_oe_n, sdo, sdo_oe_n, sck, fs, sdi;

    always #4 clk = ~clk;

    csm_codec_serial dut (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_clock_pin_i(sck_oe_n ? sck : sck_o), .bit_clock_pin_o(sck_o), .bit_clock_pin_oe_n(sck_oe_n),
        .frame_sync_pin_i(fs_oe_n ? fs : fs_o), .frame_sync_pin_o(fs_o), .frame_sync_pin_oe_n(fs_oe_n),
        .serial_out_pin_o(sdo), .serial_out_pin_oe_n(sdo_oe_n), .serial_in_pin_i(sdi));

    csm_codec_partner codec (.clk(clk), .rst(rst), .ext(ext), .word(word), .sck(sck), .fs(fs), .sdi(sdi));

    ////////////////////////////////////////
    task automatic complete_run;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            complete_run;
        end
    endtask

    // Poll status until a flag rises; polling never clears it
    task automatic wait_stat(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, `CSM_OFF_STAT, 16'h0000);
            n++;
        end while (q[b] !== 1'b1 && n < 400);
        if (q[b] !== 1'b1) begin
            fail_count++;
            complete_run;
        end
    endtask

    task automatic setup(input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] tx_slot_enable);
        apb(1'b1, `CSM_OFF_CTRL1, 16'h0000);
        apb(1'b1, `CSM_OFF_CTRL2, c2);
        apb(1'b1, `CSM_OFF_CTRL3, 16'h0001);
        apb(1'b1, `CSM_OFF_RSE, 16'h0001);
        apb(1'b1, `CSM_OFF_TSE, tx_slot_enable);
        apb(1'b1, `CSM_OFF_CTRL1, c1);
    endtask

    ////////////////////////////////////////
    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 16'h0000);
            chk("reset value", 32'h0, q);
        end
        apb(1'b1, `CSM_OFF_CTRL2, 16'hFFFF);
        apb(1'b0, `CSM_OFF_CTRL2, 16'h0000);
        chk("control 2 fields", {16'h0000, `CSM_MASK_CTRL2}, q);
        apb(1'b1, `CSM_OFF_CTRL3, 16'hFFFF);
        apb(1'b0, `CSM_OFF_CTRL3, 16'h0000);
        chk("divider width", 32'h0FFF, q);
        apb(1'b1, `CSM_OFF_STAT, 16'hFFFF);
        apb(1'b0, `CSM_OFF_STAT, 16'h0000);
        chk("status read only", 32'h0, q);
        apb(1'b1, `CSM_OFF_TSE, 16'hFFFF);
        apb(1'b0, `CSM_OFF_TSE, 16'h0000);
        chk("tx slot enables", 32'hFFFF, q);
        apb(1'b0, 8'h40, 16'h0000);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("t_regs done");
    endtask

    // Loopback: shift out, shift back in, read left-justified word
    task automatic run_loop(input logic [3:0] ws, input logic [15:0] tx, input logic [15:0] exp);
        logic [31:0] got;
        apb(1'b1, 8'h30, tx);
        setup(16'h8800, {12'h000, ws}, 16'h0001);
        repeat (3) begin
            wait_stat(2);
            apb(1'b0, 8'h20, 16'h0000);
            got = q;
            apb(1'b1, 8'h30, tx);
        end
        chk("loopback word", {16'h0000, exp}, got);
    endtask

    task automatic t_loop16;
        run_loop(4'hF, 16'hA5C3, 16'hA5C3);
        $display("t_loop16 done");
    endtask

    task automatic t_short;
        run_loop(4'h7, 16'h5AFF, 16'h5A00);
        $display("t_short done");
    endtask

    // Stop refilling: underflow sends zeros, unread blocks overflow,
    // then underflow mode resends the last written word
    task automatic t_unf;
        logic [31:0] got;
        repeat (3) begin
            wait_stat(2);
            apb(1'b0, 8'h20, 16'h0000);
            got = q;
        end
        apb(1'b0, `CSM_OFF_STAT, 16'h0000);
        chk("underflow flag", 32'h2, q & 32'h2);
        chk("zeros on underflow", 32'h0, got);
        wait_stat(3);
        chk("full with overflow", 32'h4, q & 32'h4);
        apb(1'b1, `CSM_OFF_CTRL1, 16'h8880);
        repeat (3) begin
            wait_stat(2);
            apb(1'b0, 8'h20, 16'h0000);
        end
        chk("last value on underflow", 32'h5A00, q);
        $display("t_unf done");
    endtask

    // Codec supplies clock and sync; data slot disabled floats
    task automatic t_ext;
        logic [31:0] got;
        word <= 16'h3C96;
        ext  <= 1'b1;
        setup(16'h8540, 16'h000F, 16'h0000);
        repeat (2) begin
            wait_stat(2);
            apb(1'b0, 8'h20, 16'h0000);
            got = q;
        end
        chk("external rx word", 32'h3C96, got);
        chk("clock pin input", 32'h1, {31'h0, sck_oe_n});
        chk("sync pin input", 32'h1, {31'h0, fs_oe_n});
        chk("unused slot floats", 32'h1, {31'h0, sdo_oe_n});
        apb(1'b1, `CSM_OFF_CTRL1, 16'h0000);
        ext <= 1'b0;
        $display("t_ext done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_loop16;
        t_short;
        t_unf;
        t_ext;
        complete_run;
    end
endmodule
